// File: logic/occh_consts.svh
`ifndef OCCH_CONSTS_SVH
`define OCCH_CONSTS_SVH

// Register word indices on the plain register port
`define OCCH_OFF_CTL1      3'h0
`define OCCH_OFF_CTL2      3'h1
`define OCCH_OFF_PRI       3'h2
`define OCCH_OFF_SEC       3'h3
`define OCCH_OFF_TMR       3'h4

// Field positions in compare_control_one
`define OCCH_B_IDLE        13
`define OCCH_B_CSEL        10
`define OCCH_B_FEN         7
`define OCCH_B_FSTAT       4
`define OCCH_B_TRIGM       3
`define OCCH_B_MODE        0

// Field positions in the second control word
`define OCCH_B_FOUT        14
`define OCCH_B_TRIG        7
`define OCCH_B_TSTAT       6

// Reset values
`define OCCH_RST_WORD      16'h0000
`define OCCH_RST_CSEL      3'h0

// Timer clock selector codes
`define OCCH_CSEL_SECOND   3'h0
`define OCCH_CSEL_THIRD    3'h1
`define OCCH_CSEL_FOURTH   3'h2
`define OCCH_CSEL_FIFTH    3'h3
`define OCCH_CSEL_FIRST    3'h4
`define OCCH_CSEL_PERIPH   3'h7

`endif

// File: logic/occh_pkg.sv
package occh_pkg;

    // Compare mode field encodings
    typedef enum logic [2:0] {
        mode_off        = 3'h0,
        mode_shot_high  = 3'h1,
        mode_shot_low   = 3'h2,
        mode_toggle     = 3'h3,
        mode_dbl_shot   = 3'h4,
        mode_dbl_cont   = 3'h5,
        mode_pwm_edge   = 3'h6,
        mode_pwm_center = 3'h7
    } occh_mode_t;

    // Writable fields of compare_control_one
    typedef struct packed {
        logic       idle_halt_sel;
        logic [2:0] timer_clock_sel;
        logic       fault_a_enable;
        logic       trig_clear_mode;
        occh_mode_t compare_mode_sel;
    } occh_ctl_t;

    // Register port request
    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } occh_bus_t;

endpackage

// File: logic/occh_sync.sv
module occh_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// File: logic/occh_tick.sv
`include "occh_consts.svh"

module occh_tick (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [4:0] clk_sync,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [4:0] prev;
    logic [4:0] rise;

    // Previous level of each synchronised timer clock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev <= '0;
        end else begin
            prev <= clk_sync;
        end
    end

    assign rise = clk_sync & ~prev;

    // Source selection; reserved codes give no tick
    always_comb begin
        case (sel)
            `OCCH_CSEL_SECOND: tick = rise[1];
            `OCCH_CSEL_THIRD:  tick = rise[2];
            `OCCH_CSEL_FOURTH: tick = rise[3];
            `OCCH_CSEL_FIFTH:  tick = rise[4];
            `OCCH_CSEL_FIRST:  tick = rise[0];
            `OCCH_CSEL_PERIPH: tick = 1'b1;
            default:           tick = 1'b0;
        endcase
    end
endmodule

// File: logic/occh_channel.sv
// Behaviour
// - Timer clock picked by 3-bit selector; codes 101 and 110 give no clock.
// - Stop-in-idle bit set halts the channel while the CPU idles.
// - Fault-A enable bit gates the fault pin; cleared means pin ignored.
// - Fault condition in a PWM mode sets fault status bit; software reads and writes it.
// - Trigger clear mode lets a secondary match clear the trigger flag.
// - Center PWM: high at primary match, low at secondary match.
// - Edge PWM: high at timer zero, low at primary match.
// - Double continuous: start low, toggle on alternating primary and secondary matches.
// - Double single shot: start low, toggle at primary then secondary, once.
// - Single compare toggle: toggle on every primary match.
// - Mode 010: start high, forced low on primary match.
// - Mode 001: start low, forced high on primary match.
// - Mode 000 disables the channel with no compare activity.
// - Compare values double-buffered only in PWM modes, else direct.
// - Primary matches, and secondary matches in the double and center PWM modes, raise interrupt and DMA request pulses.
// - Out of reset the channel follows the sync source; software must run it.
// - Unimplemented control bits ignore writes and read zero.
// - Trigger flag reads 1 while triggered and running, 0 while held clear.
// - On a fault the PWM output takes the fault-out level.
// - Trigger/sync select: 1 triggers from source, 0 synchronises the timer.
`include "occh_consts.svh"

module occh_channel (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire occh_pkg::occh_bus_t bus,
    output logic [15:0]             rdata,
    input  wire logic [4:0]         timer_clk_pins,
    input  wire logic               cpu_idle,
    input  wire logic               fault_a_pin,
    input  wire logic               sync_source_event,
    output logic                    compare_output_pin,
    output logic                    irq_match,
    output logic                    dma_req
);
    import occh_pkg::*;

    occh_ctl_t   ctl;
    logic        fault_a_status;
    logic        trig_or_sync_sel;
    logic        fault_out_level;
    logic        trigger_status_flag;
    logic [15:0] pri_buf;
    logic [15:0] sec_buf;
    logic [15:0] pri_act;
    logic [15:0] sec_act;
    logic [15:0] pri_eff;
    logic [15:0] sec_eff;
    logic [15:0] channel_timer;
    logic [4:0]  clk_sync;
    logic        fault_sync;
    logic        tick;
    logic        wr_ctl1;
    logic        wr_ctl2;
    logic        wr_pri;
    logic        wr_sec;
    logic        is_pwm;
    logic        uses_sec;
    logic        run;
    logic        hold;
    logic        step;
    logic        match_p;
    logic        match_s;
    logic        fault_set;
    logic        fault_active;
    logic        trig_set;
    logic        trig_hw_clr;
    logic        mode_load;
    logic        alt_sec;
    logic        shot_done;
    logic        next_pin;
    logic        next_alt;
    logic        next_done;

    // Pin inputs pass two flip-flops
    occh_sync #(
        .WIDTH (6)
    ) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   ({fault_a_pin, timer_clk_pins}),
        .dout  ({fault_sync, clk_sync})
    );

    // Timer clock source selection
    occh_tick u_tick (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clk_sync (clk_sync),
        .sel      (ctl.timer_clock_sel),
        .tick     (tick)
    );

    // Write decode
    assign wr_ctl1 = bus.wr && (bus.addr == `OCCH_OFF_CTL1);
    assign wr_ctl2 = bus.wr && (bus.addr == `OCCH_OFF_CTL2);
    assign wr_pri  = bus.wr && (bus.addr == `OCCH_OFF_PRI);
    assign wr_sec  = bus.wr && (bus.addr == `OCCH_OFF_SEC);

    // Mode classes and run conditions
    assign is_pwm   = (ctl.compare_mode_sel == mode_pwm_edge) || (ctl.compare_mode_sel == mode_pwm_center);
    assign uses_sec = (ctl.compare_mode_sel == mode_dbl_shot) || (ctl.compare_mode_sel == mode_dbl_cont)
                   || (ctl.compare_mode_sel == mode_pwm_center);
    assign run  = (ctl.compare_mode_sel != mode_off) && !(ctl.idle_halt_sel && cpu_idle);
    assign hold = trig_or_sync_sel && !trigger_status_flag;
    assign step = run && !hold && tick;

    // Effective compare values: shadow copies only in PWM modes
    assign pri_eff = is_pwm ? pri_act : pri_buf;
    assign sec_eff = is_pwm ? sec_act : sec_buf;

    assign match_p = step && (channel_timer == pri_eff);
    assign match_s = step && (channel_timer == sec_eff);

    assign fault_set    = ctl.fault_a_enable && fault_sync && is_pwm;
    assign fault_active = fault_a_status && is_pwm;
    assign trig_set     = trig_or_sync_sel && sync_source_event;
    assign trig_hw_clr  = ctl.trig_clear_mode && step && (channel_timer == sec_eff);
    assign mode_load    = wr_ctl1 && (bus.wdata[`OCCH_B_MODE +: 3] != ctl.compare_mode_sel);

    // Control word one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl <= '{idle_halt_sel: 1'b0, timer_clock_sel: `OCCH_RST_CSEL, fault_a_enable: 1'b0,
                     trig_clear_mode: 1'b0, compare_mode_sel: mode_off};
        end else if (wr_ctl1) begin
            ctl.idle_halt_sel    <= bus.wdata[`OCCH_B_IDLE];
            ctl.timer_clock_sel  <= bus.wdata[`OCCH_B_CSEL +: 3];
            ctl.fault_a_enable   <= bus.wdata[`OCCH_B_FEN];
            ctl.trig_clear_mode  <= bus.wdata[`OCCH_B_TRIGM];
            ctl.compare_mode_sel <= occh_mode_t'(bus.wdata[`OCCH_B_MODE +: 3]);
        end
    end

    // Fault status: hardware set wins over a software write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_a_status <= 1'b0;
        end else if (fault_set) begin
            fault_a_status <= 1'b1;
        end else if (wr_ctl1) begin
            fault_a_status <= bus.wdata[`OCCH_B_FSTAT];
        end
    end

    // Second control word subset; reset selects sync from the source
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trig_or_sync_sel <= 1'b0;
            fault_out_level  <= 1'b0;
        end else if (wr_ctl2) begin
            trig_or_sync_sel <= bus.wdata[`OCCH_B_TRIG];
            fault_out_level  <= bus.wdata[`OCCH_B_FOUT];
        end
    end

    // Trigger flag: source set wins, then software, then hardware clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trigger_status_flag <= 1'b0;
        end else if (trig_set) begin
            trigger_status_flag <= 1'b1;
        end else if (wr_ctl2) begin
            trigger_status_flag <= bus.wdata[`OCCH_B_TSTAT];
        end else if (trig_hw_clr) begin
            trigger_status_flag <= 1'b0;
        end
    end

    // Compare value buffers written by software
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pri_buf <= `OCCH_RST_WORD;
            sec_buf <= `OCCH_RST_WORD;
        end else begin
            if (wr_pri) begin
                pri_buf <= bus.wdata;
            end
            if (wr_sec) begin
                sec_buf <= bus.wdata;
            end
        end
    end

    // Active copies follow buffers outside PWM, reload at period start in PWM
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pri_act <= `OCCH_RST_WORD;
            sec_act <= `OCCH_RST_WORD;
        end else if (!is_pwm || (step && channel_timer == 16'h0000)) begin
            pri_act <= pri_buf;
            sec_act <= sec_buf;
        end
    end

    // Channel timer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            channel_timer <= `OCCH_RST_WORD;
        end else if (hold) begin
            channel_timer <= 16'h0000;
        end else if (run && !trig_or_sync_sel && sync_source_event) begin
            channel_timer <= 16'h0000;
        end else if (step) begin
            channel_timer <= channel_timer + 16'h0001;
        end
    end

    // Output pin next state per mode
    always_comb begin
        next_pin  = compare_output_pin;
        next_alt  = alt_sec;
        next_done = shot_done;
        if (mode_load) begin
            next_pin  = (bus.wdata[`OCCH_B_MODE +: 3] == mode_shot_low);
            next_alt  = 1'b0;
            next_done = 1'b0;
        end else if (fault_active) begin
            next_pin = fault_out_level;
        end else begin
            case (ctl.compare_mode_sel)
                mode_off: begin
                    next_pin = 1'b0;
                end
                mode_shot_high: begin
                    if (match_p) begin
                        next_pin = 1'b1;
                    end
                end
                mode_shot_low: begin
                    if (match_p) begin
                        next_pin = 1'b0;
                    end
                end
                mode_toggle: begin
                    if (match_p) begin
                        next_pin = !compare_output_pin;
                    end
                end
                mode_dbl_shot: begin
                    if (!shot_done && ((!alt_sec && match_p) || (alt_sec && match_s))) begin
                        next_pin  = !compare_output_pin;
                        next_alt  = !alt_sec;
                        next_done = alt_sec;
                    end
                end
                mode_dbl_cont: begin
                    if ((!alt_sec && match_p) || (alt_sec && match_s)) begin
                        next_pin = !compare_output_pin;
                        next_alt = !alt_sec;
                    end
                end
                mode_pwm_edge: begin
                    if (match_p) begin
                        next_pin = 1'b0;
                    end else if (step && channel_timer == 16'h0000) begin
                        next_pin = 1'b1;
                    end
                end
                mode_pwm_center: begin
                    if (match_s) begin
                        next_pin = 1'b0;
                    end else if (match_p) begin
                        next_pin = 1'b1;
                    end
                end
                default: begin
                    next_pin = 1'b0;
                end
            endcase
        end
    end

    // Output pin and sequence state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            compare_output_pin <= 1'b0;
            alt_sec            <= 1'b0;
            shot_done          <= 1'b0;
        end else begin
            compare_output_pin <= next_pin;
            alt_sec            <= next_alt;
            shot_done          <= next_done;
        end
    end

    // Match event pulses for interrupt and DMA
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_match <= 1'b0;
            dma_req   <= 1'b0;
        end else begin
            irq_match <= match_p || (match_s && uses_sec);
            dma_req   <= match_p || (match_s && uses_sec);
        end
    end

    // Read data one cycle after the strobe; reserved bits read zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= `OCCH_RST_WORD;
        end else if (bus.rd) begin
            rdata <= 16'h0000;
            case (bus.addr)
                `OCCH_OFF_CTL1: begin
                    rdata[`OCCH_B_IDLE]       <= ctl.idle_halt_sel;
                    rdata[`OCCH_B_CSEL +: 3]  <= ctl.timer_clock_sel;
                    rdata[`OCCH_B_FEN]        <= ctl.fault_a_enable;
                    rdata[`OCCH_B_FSTAT]      <= fault_a_status;
                    rdata[`OCCH_B_TRIGM]      <= ctl.trig_clear_mode;
                    rdata[`OCCH_B_MODE +: 3]  <= ctl.compare_mode_sel;
                end
                `OCCH_OFF_CTL2: begin
                    rdata[`OCCH_B_FOUT]  <= fault_out_level;
                    rdata[`OCCH_B_TRIG]  <= trig_or_sync_sel;
                    rdata[`OCCH_B_TSTAT] <= trigger_status_flag;
                end
                `OCCH_OFF_PRI: rdata <= pri_buf;
                `OCCH_OFF_SEC: rdata <= sec_buf;
                `OCCH_OFF_TMR: rdata <= channel_timer;
                default:       rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_clock_reserved: assert property ((ctl.timer_clock_sel == 3'h5 || ctl.timer_clock_sel == 3'h6) |-> !tick)
        else $error("tick from reserved clock code");
    a_idle_halt: assert property (ctl.idle_halt_sel && cpu_idle |-> !step)
        else $error("timer stepped while halted in idle");
    a_fault_ignored: assert property (!ctl.fault_a_enable && !fault_a_status && !wr_ctl1 |=> !fault_a_status)
        else $error("disabled fault pin set status");
    a_fault_sets: assert property (fault_set |=> fault_a_status)
        else $error("fault did not set status");
    a_trig_hw_clear: assert property (trig_hw_clr && !trig_set && !wr_ctl2 |=> !trigger_status_flag)
        else $error("secondary match did not clear trigger flag");
    a_center_edges: assert property (ctl.compare_mode_sel == mode_pwm_center && match_p && !match_s
                                     && !fault_active && !mode_load |=> compare_output_pin)
        else $error("center pwm did not rise on primary match");
    a_edge_low: assert property (ctl.compare_mode_sel == mode_pwm_edge && match_p && !fault_active
                                 && !mode_load |=> !compare_output_pin)
        else $error("edge pwm did not fall on primary match");
    a_toggle_match: assert property (ctl.compare_mode_sel == mode_toggle && match_p && !wr_ctl1
                                     |=> compare_output_pin != $past(compare_output_pin))
        else $error("toggle mode did not toggle");
    a_off_quiet: assert property (ctl.compare_mode_sel == mode_off && !wr_ctl1 |=> !irq_match ##1 !irq_match)
        else $error("disabled channel raised a match");
    a_fault_level: assert property (fault_active && !mode_load |=> compare_output_pin == $past(fault_out_level))
        else $error("fault level not driven");
    a_hold_clear: assert property (hold |=> channel_timer == 16'h0000)
        else $error("held timer not clear");
    a_direct_write: assert property (!is_pwm && wr_pri && !wr_ctl1 |=> pri_eff == $past(bus.wdata))
        else $error("direct compare write not effective");
    a_match_pulse: assert property (match_p |=> irq_match && dma_req ##1 (irq_match == $past(match_p || match_s && uses_sec)))
        else $error("match pulse missing");
endmodule

// File: verification/occh_load.sv
module occh_load (
    input  wire logic mclk,
    input  wire logic fault_req,
    output logic      fault_a_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Fault source holds its level until told to drop it
    always @(posedge mclk) begin
        fault_a_pin <= fault_req;
    end
endmodule

// File: verification/occh_channel_tb.sv
module occh_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import occh_pkg::*;

    logic        mclk, rst_n, cpu_idle, fault_req, sync_ev;
    logic        rd_seen = 1'b0;
    logic        fault_pin, out_pin, irq, dma;
    occh_bus_t   bus;
    logic [15:0] rdata, v;
    logic [4:0]  ck_pins = 5'h00;
    logic [4:0]  ck_mask;
    logic [3:0]  ck_cnt = 4'h0;
    logic [2:0]  m;
    logic [31:0] lf = 32'ha0e3;
    int          num_errors, compares;
    logic [15:0] rq[$];
    logic        pq[$];

    occh_channel u_occh_channel (
        .mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .timer_clk_pins(ck_pins),
        .cpu_idle(cpu_idle), .fault_a_pin(fault_pin), .sync_source_event(sync_ev),
        .compare_output_pin(out_pin), .irq_match(irq), .dma_req(dma));
    occh_load u_occh_load (.mclk(mclk), .fault_req(fault_req), .fault_a_pin(fault_pin));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic bw(input logic [2:0] a, input logic [15:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
        @(posedge mclk);
    endtask

    // Read note goes in the queue; the monitor compares it a cycle later
    task automatic br(input logic [2:0] a, input logic [15:0] e);
        rq.push_back(e);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic sync_pulse;
        sync_ev <= 1'b1;
        @(posedge mclk);
        sync_ev <= 1'b0;
        @(posedge mclk);
    endtask

    // Bounded wait for every noted match to show up
    task automatic wait_q(input int n);
        for (int i = 0; i < n && pq.size() != 0; i++) @(posedge mclk);
        cmp(16'(pq.size()), 16'h0000);
        pq.delete();
    endtask

    // Mode off, timer held clear by trigger mode, compare values loaded, then the mode started
    task automatic setup(input logic [15:0] ctl, input logic [15:0] pri, input logic [15:0] sec);
        bw(3'h0, ctl & 16'hfff8);
        bw(3'h1, 16'h0080);
        bw(3'h1, 16'h0000);
        bw(3'h2, pri);
        bw(3'h3, sec);
        bw(3'h0, ctl);
    endtask

    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Selected clock pin gets a square wave, the others random levels
    always @(posedge mclk) begin
        lf <= lfsr_next(lf);
        ck_cnt <= ck_cnt + 4'h1;
        ck_pins <= (lf[4:0] & ~ck_mask) | (ck_cnt[2] ? ck_mask : 5'h00);
    end

    // Monitor takes the oldest note whenever read data or a match appears
    always @(posedge mclk) begin
        if (rd_seen === 1'b1) cmp(rdata, rq.pop_front());
        if (irq === 1'b1) begin
            cmp(16'(dma), 16'h0001);
            cmp(16'(out_pin), pq.size() > 0 ? 16'(pq.pop_front()) : 16'hdead);
        end
        rd_seen <= bus.rd;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        cpu_idle = 1'b0;
        fault_req = 1'b0;
        sync_ev = 1'b0;
        bus = '0;
        ck_mask = 5'h00;
        num_errors = 0;
        compares = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        br(3'h0, 16'h0000);
        br(3'h1, 16'h0000);
        bw(3'h0, 16'hfff8);
        br(3'h0, 16'h3c98);
        v = lf[15:0];
        bw(3'h5, v);
        br(3'h5, 16'h0000);
        bw(3'h2, v);
        br(3'h2, v);
        bw(3'h4, 16'h1234);
        br(3'h4, 16'h0000);
        bw(3'h0, 16'h0000);
        // Non-PWM and center modes: start level, then match levels
        for (int i = 0; i < 6; i++) begin
            m = 3'(20'h3d8d1 >> (3 * i));
            cpu_idle <= lf[9];
            setup(16'h1c00 | 16'(m), 16'h0008, 16'h000c);
            cyc(1);
            cmp(16'(out_pin), 16'(m == 3'h2));
            pq.push_back(m != 3'h2);
            if (m >= 3'h4) pq.push_back(1'b0);
            wait_q(40);
            if (m == 3'h3 || m == 3'h5) begin
                sync_pulse();
                pq.push_back(m == 3'h5);
                if (m == 3'h5) pq.push_back(1'b0);
                wait_q(40);
            end
        end
        // Edge PWM with fault pin, first ignored then honoured
        setup(16'h1c06, 16'h0004, 16'h0000);
        cyc(3);
        cmp(16'(out_pin), 16'h0001);
        pq.push_back(1'b0);
        fault_req <= 1'b1;
        cyc(6);
        br(3'h0, 16'h1c06);
        bw(3'h0, 16'h1c86);
        cyc(4);
        br(3'h0, 16'h1c96);
        cmp(16'(out_pin), 16'h0000);
        bw(3'h1, 16'h4000);
        cyc(1);
        cmp(16'(out_pin), 16'h0001);
        fault_req <= 1'b0;
        cyc(5);
        bw(3'h0, 16'h1c86);
        br(3'h0, 16'h1c86);
        bw(3'h1, 16'h0000);
        // Idle halt holds the timer until the CPU wakes
        setup(16'h1c00, 16'h0002, 16'h0000);
        cpu_idle <= 1'b1;
        bw(3'h0, 16'h3c03);
        cyc(10);
        br(3'h4, 16'h0000);
        pq.push_back(1'b1);
        cpu_idle <= 1'b0;
        wait_q(20);
        // Each pin clock code counts only its own pin
        for (int c = 0; c < 5; c++) begin
            ck_mask <= 5'(1 << ((c + 1) % 5));
            setup(16'h0003 | 16'(c << 10), 16'h0001, 16'h0000);
            pq.push_back(1'b1);
            wait_q(100);
            br(3'h4, 16'h0002);
            bw(3'h0, 16'h0000);
        end
        ck_mask <= 5'h1f;
        setup(16'h1403, 16'h0001, 16'h0000);
        cyc(40);
        br(3'h4, 16'h0000);
        ck_mask <= 5'h00;
        // Trigger mode: held clear until the source fires
        bw(3'h0, 16'h1c08);
        sync_pulse();
        bw(3'h2, 16'h0002);
        bw(3'h3, 16'h0005);
        bw(3'h1, 16'h0080);
        br(3'h1, 16'h0080);
        bw(3'h0, 16'h1c0c);
        cyc(10);
        br(3'h4, 16'h0000);
        pq.push_back(1'b1);
        pq.push_back(1'b0);
        sync_pulse();
        br(3'h1, 16'h00c0);
        wait_q(40);
        br(3'h1, 16'h0080);
        bw(3'h1, 16'h0000);
        bw(3'h0, 16'h0000);
        cyc(5);
        report_and_stop();
    end
endmodule
